/* File: mcdp_engine.v */
`timescale 1ns/1ns
`include "mcdp_map.vh"
// ==========================================
// What this block does
// RULE1 - Multiplex eight or sixteen lines, both ways
// RULE2 - Receiver flags a fully assembled character
// RULE3 - Transmitter flags readiness for next character
// RULE4 - Scanner polls one line flag at a time
// RULE5 - Sequencer runs continuously once host starts it
// RULE6 - Receive FIFO holds 128 characters
// RULE7 - Lone FIFO entry visible at output immediately
// RULE8 - Fetch control byte addressed by character code
// RULE9 - Host table gives control byte per code
// RULE10 - Store flag writes character to host memory
// RULE11 - Interrupt flag parks character, raises interrupt
// RULE12 - Held register shows line and error flags
// RULE13 - Host supplies instruction for held character
// RULE14 - FIFO fills but receive processing stalls
// RULE15 - Transmit servicing continues during receive stall
// RULE16 - Transmit: read character, then its control byte
// RULE17 - Load transmitter only after control byte
// RULE18 - Scratch RAM holds addresses and counts
// RULE19 - Scratch RAM holds per-line protocol word
// RULE20 - Block check accumulates only over characters whose control byte sets the BCC bit
// RULE21 - Full FIFO drops character, flags overrun
// RULE22 - FIFO characters serviced in arrival order
module mcdp_engine #(
	parameter LINES = `MCDP_LINES_MAX,
	parameter LW    = 4,
	parameter AW    = 18
) (
	input  wire            clk_sys,
	input  wire            rst,
	input  wire            run,
	input  wire [AW-1:0]   ctl_table_base,
	input  wire [LINES-1:0] rx_flag,
	input  wire [7:0]      rx_char,
	input  wire [1:0]      rx_err,
	output reg  [LINES-1:0] rx_take,
	input  wire [LINES-1:0] tx_flag,
	output reg  [LINES-1:0] tx_load,
	output reg  [7:0]      tx_char,
	output reg             bus_master_request,
	output reg             bus_write,
	output reg  [AW-1:0]   bus_addr,
	output reg  [7:0]      bus_wdata,
	input  wire            bus_ack,
	input  wire [7:0]      bus_rdata,
	output reg             host_irq,
	output reg  [7:0]      held_interrupt_char_reg,
	output reg  [LW-1:0]   held_line,
	output reg  [1:0]      held_err,
	input  wire            host_instr_valid,
	input  wire [1:0]      host_instr,
	input  wire            ram_we,
	input  wire [LW+2:0]   ram_addr,
	input  wire [15:0]     ram_wdata,
	output wire [15:0]     ram_rdata,
	output wire [15:0]     proto_word,
	output wire            rx_overrun
);
	// ==========================================
	// States, one-hot
	localparam S_IDLE  = 10'h001;
	localparam S_SCAN  = 10'h002;
	localparam S_RXCB  = 10'h004;
	localparam S_RXACT = 10'h008;
	localparam S_RXST  = 10'h010;
	localparam S_TXCH  = 10'h020;
	localparam S_TXCB  = 10'h040;
	localparam S_TXLD  = 10'h080;
	localparam S_CNT   = 10'h100;
	localparam S_BCC   = 10'h200;
	reg  [9:0]     state;
	reg  [LW-1:0]  scan_line;
	reg  [LW-1:0]  cur_line;
	reg            cur_is_tx;
	reg  [7:0]     cur_char;
	reg  [7:0]     cur_cb;
	reg            held;
	reg            rel_store;
	reg  [2:0]     sel;
	reg            sram_we;
	reg  [15:0]    sram_wdata;
	wire [15:0]    sram_rdata;
	wire [LW+2:0]  sram_addr;
	wire [13:0]    fifo_head;
	wire           fifo_valid;
	reg            fifo_pop;
	reg            fifo_push;
	reg  [13:0]    fifo_in;
	// ==========================================
	// Helpers
	function [AW-1:0] cb_addr;
		input [AW-1:0] base;
		input [7:0]    code;
		begin
			cb_addr = base + {{(AW-8){1'b0}}, code};
		end
	endfunction
	// Scratch words are 16 bits, so upper address bits stay zero
	function [AW-1:0] word_addr;
		input [15:0] w;
		begin
			word_addr = {{(AW-16){1'b0}}, w};
		end
	endfunction
	function [15:0] bcc_step;
		input [15:0] crc;
		input [7:0]  d;
		integer      k;
		reg   [15:0] c;
		begin
			c = crc ^ {8'h00, d};
			for (k = 0; k < 8; k = k + 1) begin
				c = c[0] ? ((c >> 1) ^ `MCDP_BCC_POLY) : (c >> 1);
			end
			bcc_step = c;
		end
	endfunction
	// ==========================================
	// Receive capture into FIFO: one receiver per cycle, scanned
	reg [LW-1:0] cap_line;
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cap_line  <= {LW{1'b0}};
			fifo_push <= 1'b0;
			fifo_in   <= 14'h0000;
			rx_take   <= {LINES{1'b0}};
		end else begin
			fifo_push <= 1'b0;
			rx_take   <= {LINES{1'b0}};
			cap_line  <= (cap_line == LINES-1) ? {LW{1'b0}} : cap_line + 1'b1; // RULE4
			// Keeps filling even while receive processing is stalled
			if (run && rx_flag[cap_line] && !rx_take[cap_line]) begin // RULE2 RULE14
				fifo_push         <= 1'b1;
				fifo_in           <= {rx_err, cap_line, rx_char};
				rx_take[cap_line] <= 1'b1;
			end
		end
	end
	mcdp_rx_fifo #(
		.WIDTH (14),
		.AW    (`MCDP_FIFO_AW)
	) u_fifo (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.wr_valid (fifo_push),
		.wr_data  (fifo_in),
		.wr_ready (),
		.rd_valid (fifo_valid),
		.rd_data  (fifo_head),
		.rd_ready (fifo_pop),
		.overrun  (rx_overrun)
	);
	// ==========================================
	// Scratch RAM
	assign sram_addr = {cur_line, sel}; // RULE18 RULE19
	mcdp_scratch_ram #(
		.LW (LW)
	) u_ram (
		.clk_sys (clk_sys),
		.we_a    (ram_we),
		.addr_a  (ram_addr),
		.wdata_a (ram_wdata),
		.rdata_a (ram_rdata),
		.we_b    (sram_we),
		.addr_b  (sram_addr),
		.wdata_b (sram_wdata),
		.rdata_b (sram_rdata)
	);
	assign proto_word = sram_rdata;
	// Write in the cycle the word is read, while the select still points at it
	always @* begin
		sram_we    = 1'b0;
		sram_wdata = sram_rdata;
		case (state)
			S_RXST: begin
				sram_we    = bus_ack;
				sram_wdata = sram_rdata + 16'h0001;
			end
			S_TXCH: begin
				sram_we    = bus_master_request && bus_ack;
				sram_wdata = sram_rdata + 16'h0001;
			end
			S_CNT: begin
				// Count saturates at zero; the host reloads it
				sram_we    = (sram_rdata != 16'h0000);
				sram_wdata = sram_rdata - 16'h0001; // RULE18
			end
			S_BCC: begin
				sram_we    = cur_cb[`MCDP_CB_BCC];
				sram_wdata = bcc_step(sram_rdata, cur_char); // RULE20
			end
			default: begin
				sram_we    = 1'b0;
			end
		endcase
	end
	// ==========================================
	// Microsequencer
	always @* begin
		sel = `MCDP_RAM_PROTO;
		case (state)
			S_RXST:  sel = `MCDP_RAM_RXADDR;
			S_TXCH:  sel = `MCDP_RAM_TXADDR;
			S_CNT:   sel = cur_is_tx ? `MCDP_RAM_TXCNT : `MCDP_RAM_RXCNT;
			S_BCC:   sel = `MCDP_RAM_BCC;
			S_RXACT: sel = `MCDP_RAM_RXADDR;
			default: sel = `MCDP_RAM_PROTO;
		endcase
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state                   <= S_IDLE;
			scan_line               <= {LW{1'b0}};
			cur_line                <= {LW{1'b0}};
			cur_is_tx               <= 1'b0;
			cur_char                <= 8'h00;
			cur_cb                  <= 8'h00;
			held                    <= 1'b0;
			rel_store               <= 1'b0;
			fifo_pop                <= 1'b0;
			tx_load                 <= {LINES{1'b0}};
			tx_char                 <= 8'h00;
			bus_master_request      <= 1'b0;
			bus_write               <= 1'b0;
			bus_addr                <= {AW{1'b0}};
			bus_wdata               <= 8'h00;
			host_irq                <= 1'b0;
			held_interrupt_char_reg <= 8'h00;
			held_line               <= {LW{1'b0}};
			held_err                <= 2'h0;
		end else begin
			fifo_pop <= 1'b0;
			tx_load  <= {LINES{1'b0}};
			if (held && host_instr_valid) begin // RULE13
				held      <= 1'b0;
				host_irq  <= 1'b0;
				rel_store <= (host_instr == `MCDP_HI_STORE);
			end
			case (state)
				S_IDLE: begin
					if (run) begin
						state <= S_SCAN; // RULE5
					end
				end
				S_SCAN: begin
					if (!run) begin
						state <= S_IDLE;
					end else if (rel_store) begin
						rel_store <= 1'b0;
						cur_line  <= held_line;
						cur_char  <= held_interrupt_char_reg;
						cur_is_tx <= 1'b0;
						cur_cb    <= 8'h01;
						state     <= S_RXACT;
					end else if (fifo_valid && !held && !fifo_pop) begin // RULE14 RULE22
						cur_char           <= fifo_head[7:0];
						cur_line           <= fifo_head[LW+7:8];
						held_err           <= fifo_head[13:12];
						cur_is_tx          <= 1'b0;
						bus_master_request <= 1'b1;
						bus_write          <= 1'b0;
						bus_addr           <= cb_addr(ctl_table_base, fifo_head[7:0]); // RULE8 RULE9
						state              <= S_RXCB;
					end else begin
						scan_line <= (scan_line == LINES-1) ? {LW{1'b0}} : scan_line + 1'b1; // RULE4 RULE1
						if (tx_flag[scan_line]) begin // RULE3 RULE15
							cur_line  <= scan_line;
							cur_is_tx <= 1'b1;
							state     <= S_TXCH;
						end
					end
				end
				S_RXCB: begin
					if (bus_ack) begin
						bus_master_request <= 1'b0;
						cur_cb             <= bus_rdata;
						fifo_pop           <= 1'b1;
						state              <= S_RXACT;
					end
				end
				S_RXACT: begin
					if (cur_cb[`MCDP_CB_INTR] && !held && !rel_store) begin
						held                    <= 1'b1; // RULE11
						host_irq                <= 1'b1;
						held_interrupt_char_reg <= cur_char;
						held_line               <= cur_line; // RULE12
						state                   <= S_SCAN;
					end else if (cur_cb[`MCDP_CB_STORE]) begin
						bus_master_request <= 1'b1; // RULE10
						bus_write          <= 1'b1;
						bus_addr           <= word_addr(sram_rdata);
						bus_wdata          <= cur_char;
						state              <= S_RXST;
					end else begin
						state <= S_BCC;
					end
				end
				S_RXST: begin
					if (bus_ack) begin
						bus_master_request <= 1'b0;
						bus_write          <= 1'b0;
						state              <= S_CNT;
					end
				end
				S_TXCH: begin
					if (!bus_master_request) begin
						bus_master_request <= 1'b1; // RULE16
						bus_write          <= 1'b0;
						bus_addr           <= word_addr(sram_rdata);
					end else if (bus_ack) begin
						bus_master_request <= 1'b0;
						cur_char           <= bus_rdata;
						bus_addr           <= cb_addr(ctl_table_base, bus_rdata); // RULE16
						state              <= S_TXCB;
					end
				end
				S_TXCB: begin
					// One request per transfer, so it drops between the two reads
					if (!bus_master_request) begin
						bus_master_request <= 1'b1; // RULE16
					end else if (bus_ack) begin
						bus_master_request <= 1'b0;
						cur_cb             <= bus_rdata;
						state              <= S_TXLD;
					end
				end
				S_TXLD: begin
					// Control byte already fetched before load
					if (!cur_cb[`MCDP_CB_DISCARD]) begin
						tx_load[cur_line] <= 1'b1; // RULE17
						tx_char           <= cur_char;
					end
					state <= S_CNT;
				end
				S_CNT: begin
					state <= S_BCC;
				end
				S_BCC: begin
					state <= S_SCAN;
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end
endmodule // mcdp_engine

/* File: mcdp_map.vh */
`ifndef MCDP_MAP_VH
`define MCDP_MAP_VH
// ==========================================
// Line and FIFO geometry
`define MCDP_LINES_MAX   16
`define MCDP_FIFO_DEPTH  128
`define MCDP_FIFO_AW     7
// ==========================================
// Control byte fields
`define MCDP_CB_STORE    0
`define MCDP_CB_INTR     1
`define MCDP_CB_BCC      2
`define MCDP_CB_DISCARD  3
// ==========================================
// Host instruction codes for a held character
`define MCDP_HI_STORE    2'h1
`define MCDP_HI_DISCARD  2'h2
// ==========================================
// Scratch RAM word selects per line
`define MCDP_RAM_RXADDR  3'h0
`define MCDP_RAM_RXCNT   3'h1
`define MCDP_RAM_TXADDR  3'h2
`define MCDP_RAM_TXCNT   3'h3
`define MCDP_RAM_PROTO   3'h4
`define MCDP_RAM_BCC     3'h5
// ==========================================
// Block check polynomial
`define MCDP_BCC_POLY    16'hA001
`define MCDP_RST_WORD    16'h0000
`endif

/* File: mcdp_rx_fifo.v */
`timescale 1ns/1ns
`include "mcdp_map.vh"
// ==========================================
// Received character FIFO
module mcdp_rx_fifo #(
	parameter WIDTH = 14,
	parameter AW    = `MCDP_FIFO_AW
) (
	input  wire             clk_sys,
	input  wire             rst,
	input  wire             wr_valid,
	input  wire [WIDTH-1:0] wr_data,
	output wire             wr_ready,
	output wire             rd_valid,
	output wire [WIDTH-1:0] rd_data,
	input  wire             rd_ready,
	output reg              overrun
);
	reg [WIDTH-1:0] mem [0:(1<<AW)-1];
	reg [AW:0]      wr_ptr;
	reg [AW:0]      rd_ptr;
	wire            empty;
	wire            full;
	assign empty    = (wr_ptr == rd_ptr);
	assign full     = (wr_ptr == {~rd_ptr[AW], rd_ptr[AW-1:0]}); // RULE6
	assign wr_ready = ~full;
	assign rd_valid = ~empty;
	// Head word read straight from the array, so a lone entry is visible at once
	assign rd_data  = mem[rd_ptr[AW-1:0]]; // RULE7
	always @(posedge clk_sys) begin
		if (wr_valid && !full) begin
			mem[wr_ptr[AW-1:0]] <= wr_data;
		end
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_ptr  <= {(AW+1){1'b0}};
			rd_ptr  <= {(AW+1){1'b0}};
			overrun <= 1'b0;
		end else begin
			if (wr_valid && !full) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (wr_valid && full) begin
				overrun <= 1'b1; // RULE21
			end
			if (rd_ready && !empty) begin
				rd_ptr <= rd_ptr + 1'b1; // RULE22
			end
		end
	end
endmodule // mcdp_rx_fifo

/* File: mcdp_scratch_ram.v */
`timescale 1ns/1ns
`include "mcdp_map.vh"
// ==========================================
// Per-line scratch RAM
module mcdp_scratch_ram #(
	parameter LW = 4
) (
	input  wire          clk_sys,
	input  wire          we_a,
	input  wire [LW+2:0] addr_a,
	input  wire [15:0]   wdata_a,
	output wire [15:0]   rdata_a,
	input  wire          we_b,
	input  wire [LW+2:0] addr_b,
	input  wire [15:0]   wdata_b,
	output wire [15:0]   rdata_b
);
	reg [15:0] mem [0:(1<<(LW+3))-1];
	// Port B wins a same-address collision; the host only loads idle lines
	always @(posedge clk_sys) begin
		if (we_a) begin
			mem[addr_a] <= wdata_a;
		end
		if (we_b) begin
			mem[addr_b] <= wdata_b;
		end
	end
	assign rdata_a = mem[addr_a];
	assign rdata_b = mem[addr_b];
endmodule // mcdp_scratch_ram

/* File: mcdp_engine_assertions.sv */
`timescale 1ns/1ns
// ==========================================
// Port checker
module mcdp_chk #(
	parameter LINES = 16,
	parameter LW    = 4,
	parameter AW    = 18
) (
	input wire             clk_sys,
	input wire             rst,
	input wire [LINES-1:0] rx_flag,
	input wire [LINES-1:0] rx_take,
	input wire [LINES-1:0] tx_flag,
	input wire [LINES-1:0] tx_load,
	input wire             bus_master_request,
	input wire             bus_write,
	input wire [AW-1:0]    bus_addr,
	input wire             bus_ack,
	input wire             host_irq,
	input wire [7:0]       held_interrupt_char_reg,
	input wire [LW-1:0]    held_line,
	input wire             host_instr_valid,
	input wire             rx_overrun
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ==========================================
	// Bus master cycle
	a_req_holds: assert property (bus_master_request && !bus_ack |=> bus_master_request)
		else $error("request dropped before ack");
	a_req_drops: assert property (bus_master_request && bus_ack |=> !bus_master_request)
		else $error("request kept after ack");
	a_req_stable: assert property (bus_master_request && !bus_ack |=> $stable(bus_addr) && $stable(bus_write))
		else $error("address moved during request");
	// ==========================================
	// Scanner and flags
	a_take_single: assert property ($onehot0(rx_take))
		else $error("two receivers taken at once");
	a_load_single: assert property ($onehot0(tx_load))
		else $error("two transmitters loaded at once");
	a_take_flagged: assert property (rx_take != 0 |-> (rx_take & ~$past(rx_flag)) == 0)
		else $error("receiver taken without flag");
	a_load_flagged: assert property (tx_load != 0 |-> (tx_load & ~$past(tx_flag)) == 0)
		else $error("transmitter loaded without flag");
	// ==========================================
	// Held character and overrun
	a_irq_waits: assert property (host_irq && !host_instr_valid |=> host_irq)
		else $error("interrupt dropped without host reply");
	a_held_stable: assert property (host_irq ##1 host_irq |-> $stable(held_interrupt_char_reg) && $stable(held_line))
		else $error("held character changed while waiting");
	a_overrun_sticky: assert property (rx_overrun |=> rx_overrun)
		else $error("overrun cleared");
	cover property (bus_master_request && bus_write && bus_ack);
	cover property ($rose(host_irq));
	cover property (tx_load != 0);
	cover property ($rose(rx_overrun));
endmodule // mcdp_chk
bind mcdp_engine mcdp_chk #(.LINES(LINES), .LW(LW), .AW(AW)) mcdp_chk_i (.clk_sys(clk_sys), .rst(rst),
	.rx_flag(rx_flag), .rx_take(rx_take), .tx_flag(tx_flag), .tx_load(tx_load),
	.bus_master_request(bus_master_request), .bus_write(bus_write), .bus_addr(bus_addr), .bus_ack(bus_ack),
	.host_irq(host_irq), .held_interrupt_char_reg(held_interrupt_char_reg), .held_line(held_line),
	.host_instr_valid(host_instr_valid), .rx_overrun(rx_overrun));

/* File: mcdp_host_mem.sv */
`timescale 1ns/1ns
// ==========================================
// Host memory answering bus master cycles
module mcdp_host_mem #(
	parameter AW = 18
) (
	input  wire          clk_sys,
	input  wire          bus_master_request,
	input  wire          bus_write,
	input  wire [AW-1:0] bus_addr,
	input  wire [7:0]    bus_wdata,
	input  wire          slow,
	output reg           bus_ack,
	output reg  [7:0]    bus_rdata,
	output reg  [AW-1:0] last_addr
);
	reg [7:0] mem [0:2047];
	reg [2:0] wait_cnt;
	initial begin
		bus_ack = 1'b0;
		bus_rdata = 8'h00;
		last_addr = 0;
		wait_cnt = 3'h0;
	end
	always @(posedge clk_sys) begin
		// Data outside an answer keeps changing so stale reads show
		bus_rdata <= ~bus_rdata;
		if (bus_ack) begin
			bus_ack <= 1'b0;
			wait_cnt <= 3'h0;
		end else if (bus_master_request && wait_cnt < (slow ? 3'h5 : 3'h0)) begin
			wait_cnt <= wait_cnt + 3'h1;
		end else if (bus_master_request) begin
			bus_ack <= 1'b1;
			last_addr <= bus_addr;
			if (bus_write)
				mem[bus_addr[10:0]] <= bus_wdata;
			else
				bus_rdata <= mem[bus_addr[10:0]];
		end
	end
endmodule // mcdp_host_mem

/* File: tb_mcdp_engine.sv */
`timescale 1ns/1ns
`include "mcdp_map.vh"
module tb_mcdp_engine;
	reg         clk_sys = 0;
	reg         rst = 1;
	reg         run = 0;
	reg  [15:0] rx_flag = 0;
	reg  [7:0]  rx_char = 0;
	reg  [1:0]  rx_err = 0;
	reg  [15:0] tx_flag = 0;
	reg         host_instr_valid = 0;
	reg  [1:0]  host_instr = 0;
	reg         ram_we = 0;
	reg  [6:0]  ram_addr = 0;
	reg  [15:0] ram_wdata = 0;
	reg         slow = 0;
	wire [15:0] rx_take, tx_load, ram_rdata;
	wire [7:0]  tx_char, bus_wdata, bus_rdata, held_char;
	wire [17:0] bus_addr, last_addr;
	wire [3:0]  held_line;
	wire [1:0]  held_err;
	wire [15:0] proto_word;
	wire        bus_req, bus_write, bus_ack, host_irq, rx_overrun;
	integer     error_cnt = 0;
	integer     check_count = 0;
	integer     cycles = 0;
	integer     i;
	mcdp_engine mcdp_engine_i (.clk_sys(clk_sys), .rst(rst), .run(run), .ctl_table_base(18'h00400),
		.rx_flag(rx_flag), .rx_char(rx_char), .rx_err(rx_err), .rx_take(rx_take), .tx_flag(tx_flag),
		.tx_load(tx_load), .tx_char(tx_char), .bus_master_request(bus_req), .bus_write(bus_write),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
		.host_irq(host_irq), .held_interrupt_char_reg(held_char), .held_line(held_line), .held_err(held_err),
		.host_instr_valid(host_instr_valid), .host_instr(host_instr), .ram_we(ram_we), .ram_addr(ram_addr),
		.ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .proto_word(proto_word), .rx_overrun(rx_overrun));
	mcdp_host_mem mcdp_host_mem_i (.clk_sys(clk_sys), .bus_master_request(bus_req), .bus_write(bus_write),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .slow(slow), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
		.last_addr(last_addr));
	initial forever #50 clk_sys = ~clk_sys;
	// ==========================================
	// Shared tasks
	task finish_test;
		if (error_cnt == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input [8*12-1:0] name, input [15:0] exp, input [15:0] got);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("unexpected %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	task ram_wr(input [3:0] ln, input [2:0] sel, input [15:0] d);
		begin
			@(negedge clk_sys);
			ram_we = 1'b1;
			ram_addr = {ln, sel};
			ram_wdata = d;
			@(negedge clk_sys);
			ram_we = 1'b0;
		end
	endtask
	task rx_push(input [3:0] ln, input [7:0] c, input [1:0] e);
		integer n;
		begin
			@(negedge clk_sys);
			rx_char = c;
			rx_err = e;
			rx_flag[ln] = 1'b1;
			for (n = 0; rx_take[ln] !== 1'b1 && n < 60; n = n + 1)
				@(negedge clk_sys);
			rx_flag[ln] = 1'b0;
		end
	endtask
	task wait_mem(input [10:0] a, input [7:0] v);
		integer n;
		begin
			for (n = 0; mcdp_host_mem_i.mem[a] !== v && n < 300; n = n + 1)
				@(negedge clk_sys);
			chk("host mem", {8'h00, v}, {8'h00, mcdp_host_mem_i.mem[a]});
		end
	endtask
	task wait_irq;
		integer n;
		for (n = 0; host_irq !== 1'b1 && n < 300; n = n + 1)
			@(negedge clk_sys);
	endtask
	task host_say(input [1:0] code);
		begin
			@(negedge clk_sys);
			host_instr = code;
			host_instr_valid = 1'b1;
			@(negedge clk_sys);
			host_instr_valid = 1'b0;
		end
	endtask
	function [15:0] crc8(input [15:0] c, input [7:0] d);
		integer k;
		begin
			crc8 = c ^ {8'h00, d};
			for (k = 0; k < 8; k = k + 1)
				crc8 = crc8[0] ? (crc8 >> 1) ^ `MCDP_BCC_POLY : crc8 >> 1;
		end
	endfunction
	// ==========================================
	// Scenarios
	task t_rx_store;
		integer n;
		begin
			rx_push(4'h0, 8'h41, 2'h0);
			slow = 1'b1;
			rx_push(4'h0, 8'h42, 2'h0);
			wait_mem(11'h200, 8'h41);
			wait_mem(11'h201, 8'h42);
			slow = 1'b0;
			ram_addr = {4'h0, `MCDP_RAM_BCC};
			for (n = 0; ram_rdata !== crc8(crc8(`MCDP_RST_WORD, 8'h41), 8'h42) && n < 100; n = n + 1)
				@(negedge clk_sys);
			chk("block check", crc8(crc8(`MCDP_RST_WORD, 8'h41), 8'h42), ram_rdata);
			ram_addr = {4'h0, `MCDP_RAM_RXADDR};
			#1 chk("rx address", 16'h0202, ram_rdata);
		end
	endtask
	task t_irq_stall;
		integer n;
		begin
			rx_push(4'hF, 8'h03, 2'h1);
			wait_irq;
			chk("irq", 16'h0001, {15'h0, host_irq});
			chk("held char", 16'h0003, {8'h00, held_char});
			chk("held line", 16'h000F, {12'h000, held_line});
			chk("held err", 16'h0001, {14'h0, held_err});
			rx_push(4'h0, 8'h44, 2'h0);
			tx_flag[1] = 1'b1;
			for (n = 0; tx_load[1] !== 1'b1 && n < 300; n = n + 1)
				@(negedge clk_sys);
			tx_flag[1] = 1'b0;
			chk("tx char", 16'h0055, {8'h00, tx_char});
			chk("last fetch", 16'h0455, last_addr[15:0]);
			chk("stalled mem", 16'h00FF, {8'h00, mcdp_host_mem_i.mem[11'h202]});
			host_say(`MCDP_HI_DISCARD);
			wait_mem(11'h202, 8'h44);
			chk("irq clear", 16'h0000, {15'h0, host_irq});
		end
	endtask
	task t_overrun;
		begin
			rx_push(4'hF, 8'h03, 2'h0);
			wait_irq;
			for (i = 0; i < 128; i = i + 1)
				rx_push(4'h0, 8'h44, 2'h0);
			@(negedge clk_sys);
			chk("overrun full", 16'h0000, {15'h0, rx_overrun});
			rx_push(4'h0, 8'h44, 2'h0);
			@(negedge clk_sys);
			chk("overrun", 16'h0001, {15'h0, rx_overrun});
			host_say(`MCDP_HI_STORE);
			wait_mem(11'h600, 8'h03);
		end
	endtask
	// ==========================================
	// Main sequence and hang guard
	always @(posedge clk_sys) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			error_cnt = error_cnt + 1;
			finish_test;
		end
	end
	initial begin
		for (i = 0; i < 2048; i = i + 1)
			mcdp_host_mem_i.mem[i] = 8'hFF;
		mcdp_host_mem_i.mem[11'h441] = 8'h05;
		mcdp_host_mem_i.mem[11'h442] = 8'h05;
		mcdp_host_mem_i.mem[11'h403] = 8'h02;
		mcdp_host_mem_i.mem[11'h444] = 8'h01;
		mcdp_host_mem_i.mem[11'h455] = 8'h00;
		mcdp_host_mem_i.mem[11'h300] = 8'h55;
		repeat (12) @(negedge clk_sys);
		rst = 1'b0;
		chk("reset irq", 16'h0000, {15'h0, host_irq});
		ram_wr(4'h0, `MCDP_RAM_RXADDR, 16'h0200);
		ram_wr(4'h0, `MCDP_RAM_RXCNT, 16'h00FF);
		ram_wr(4'h0, `MCDP_RAM_BCC, `MCDP_RST_WORD);
		ram_wr(4'h0, `MCDP_RAM_PROTO, 16'h5A3C);
		ram_wr(4'h1, `MCDP_RAM_TXADDR, 16'h0300);
		ram_wr(4'h1, `MCDP_RAM_TXCNT, 16'h0010);
		ram_wr(4'hF, `MCDP_RAM_RXADDR, 16'h0600);
		ram_wr(4'hF, `MCDP_RAM_RXCNT, 16'h00FF);
		ram_wr(4'h2, `MCDP_RAM_PROTO, 16'hA5C3);
		#1 chk("proto word", 16'hA5C3, ram_rdata);
		chk("proto view", 16'h5A3C, proto_word);
		run = 1'b1;
		t_rx_store;
		t_irq_stall;
		t_overrun;
		finish_test;
	end
endmodule // tb_mcdp_engine
